// ### rtl/dcc_pkg.sv
// package of register map, field layout and carriers for the decoder clock control
package dcc_pkg;
   // ===================== register offsets
   localparam logic [7:0] DCC_OFF_PLL    = 8'h00; // analog_pll_control
   localparam logic [7:0] DCC_OFF_SYS    = 8'h04; // system_clock_configuration
   localparam logic [7:0] DCC_OFF_BIT    = 8'h08; // serial_bitrate_divider_cfg
   localparam logic [7:0] DCC_OFF_SPDIF  = 8'h0C; // spdif_divider_cfg
   localparam logic [7:0] DCC_OFF_AUDIO  = 8'h10; // audio_port_configuration
   localparam logic [7:0] DCC_OFF_DBG    = 8'h14; // debug_dac_clock_cfg
   localparam logic [7:0] DCC_OFF_STAT   = 8'h18; // applied settings, read only
   localparam logic [7:0] DCC_OFF_BITEN  = 8'h1C; // bit clock gate enable
   // ===================== field positions
   localparam int DCC_SYS_SLEEP_BIT  = 3;  // sleep gate in system config
   localparam int DCC_AUD_SLAVE_BIT  = 0;  // audio slave mode
   localparam int DCC_AUD_RX_BIT     = 1;  // bit clock received, not sent
   // ===================== constants and reset values
   localparam logic [3:0] DCC_PLL_MULT      = 4'h8;  // crystal multiplier
   localparam logic [2:0] DCC_SYSTEM_DIVIDER_FIELD_MAX    = 3'h4;  // largest divider code (/32)
   localparam logic [7:0] DCC_RST_SYS       = 8'h00; // /2, awake
   localparam logic [7:0] DCC_RST_BIT       = 8'h0F; // bit clock half period - 1
   localparam logic [7:0] DCC_RST_SPDIF     = 8'h0F; // spdif half period - 1
   localparam logic [7:0] DCC_RST_DBG       = 8'h33; // debug and dac halves - 1
   localparam logic [1:0] DCC_RESP_OKAY     = 2'h0;  // axi okay
   localparam logic [1:0] DCC_RESP_SLVERR   = 2'h2;  // axi slave error
   localparam int         DCC_NCH           = 4;     // programmable dividers

   // software configuration carrier
   typedef struct packed {
      logic       crystal_16m_select;     // crystal_16m_select
      logic [7:0] sys;       // system_clock_configuration
      logic [7:0] bitdiv;    // serial_bitrate_divider_cfg
      logic       biten;     // bit clock gate enable
      logic [7:0] spdif;     // spdif_divider_cfg
      logic [1:0] audio;     // audio_port_configuration
      logic [7:0] dbg;       // debug_dac_clock_cfg
   } dcc_cfg_t;

   // averaged rf sample carrier
   typedef struct packed {
      logic       valid;     // one pulse per system clock period
      logic [5:0] data;      // average of the window
   } dcc_rf_t;
endpackage

// ### rtl/dcc_clock_control.sv
// decoder clock control: dividers, gating, rf averaging and axi4-lite registers
`timescale 1ns/1ps
module dcc_clock_control (
   input  wire logic              clk,               // master crystal clock domain
   input  wire logic              reset_n,           // async reset, active low
   input  wire logic [7:0]        s_axi_awaddr,      // write address
   input  wire logic              s_axi_awvalid,     // write address valid
   output logic                   s_axi_awready,     // write address ready
   input  wire logic [31:0]       s_axi_wdata,       // write data
   input  wire logic [3:0]        s_axi_wstrb,       // write strobes
   input  wire logic              s_axi_wvalid,      // write data valid
   output logic                   s_axi_wready,      // write data ready
   output logic [1:0]             s_axi_bresp,       // write response
   output logic                   s_axi_bvalid,      // write response valid
   input  wire logic              s_axi_bready,      // write response ready
   input  wire logic [7:0]        s_axi_araddr,      // read address
   input  wire logic              s_axi_arvalid,     // read address valid
   output logic                   s_axi_arready,     // read address ready
   output logic [31:0]            s_axi_rdata,       // read data
   output logic [1:0]             s_axi_rresp,       // read response
   output logic                   s_axi_rvalid,      // read data valid
   input  wire logic              s_axi_rready,      // read data ready
   input  wire logic              bit_clock_in,      // incoming serial bit clock pin
   input  wire logic [5:0]        rf_sample_in,      // rf converter sample
   output logic                   crystal_halve,     // analog pre-divide by two
   output logic [3:0]             pll_multiplier,    // analog multiply factor
   output logic                   rf_sample_clock,   // rf capture enable
   output logic                   system_clock,      // divided system clock
   output logic                   backend_bit_clock, // serial backend clock
   output logic                   bit_clock_out,     // bit clock pin drive
   output logic                   bit_clock_oe,      // bit clock pin enable
   output logic                   spdif_clock,       // spdif domain clock
   output logic                   debug_line_clock,  // debug line clock
   output logic                   external_dac_clock,// external dac clock
   output dcc_pkg::dcc_rf_t       rf_average         // averaged rf sample
);
   import dcc_pkg::*;

   // ===================== register bus
   dcc_cfg_t    cfg_reg, cfg_next;         // software settings
   logic        bvalid_reg, bvalid_next;   // write answer pending
   logic [1:0]  bresp_reg, bresp_next;     // write answer code
   logic        rvalid_reg, rvalid_next;   // read answer pending
   logic [1:0]  rresp_reg, rresp_next;     // read answer code
   logic [31:0] rdata_reg, rdata_next;     // read data
   logic        wr_take;                   // address and data taken together
   logic [7:0]  wd;                        // low write byte
   logic [7:0]  status;                    // applied state view

   assign wr_take       = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
   assign s_axi_awready = wr_take;
   assign s_axi_wready  = wr_take;
   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rresp   = rresp_reg;
   assign s_axi_rdata   = rdata_reg;
   assign wd            = s_axi_wdata[7:0];

   // write decode and read mux
   always_comb begin
      cfg_next    = cfg_reg;
      bvalid_next = bvalid_reg & ~s_axi_bready;
      bresp_next  = bresp_reg;
      rvalid_next = rvalid_reg & ~s_axi_rready;
      rresp_next  = rresp_reg;
      rdata_next  = rdata_reg;
      if (wr_take) begin
         bvalid_next = 1'b1;
         bresp_next  = DCC_RESP_OKAY;
         if (!s_axi_wstrb[0]) begin
            // no low lane: nothing to store
         end else if (s_axi_awaddr == DCC_OFF_PLL) begin
            cfg_next.crystal_16m_select = wd[0];
         end else if (s_axi_awaddr == DCC_OFF_SYS) begin
            cfg_next.sys = wd;
         end else if (s_axi_awaddr == DCC_OFF_BIT) begin
            cfg_next.bitdiv = wd;
         end else if (s_axi_awaddr == DCC_OFF_BITEN) begin
            cfg_next.biten = wd[0];
         end else if (s_axi_awaddr == DCC_OFF_SPDIF) begin
            cfg_next.spdif = wd;
         end else if (s_axi_awaddr == DCC_OFF_AUDIO) begin
            cfg_next.audio = wd[1:0];
         end else if (s_axi_awaddr == DCC_OFF_DBG) begin
            cfg_next.dbg = wd;
         end else if (s_axi_awaddr == DCC_OFF_STAT) begin
            // read-only: write ignored
         end else begin
            bresp_next = DCC_RESP_SLVERR;
         end
      end
      if (s_axi_arvalid && !rvalid_reg) begin
         rvalid_next = 1'b1;
         rresp_next  = DCC_RESP_OKAY;
         rdata_next  = 32'h0000_0000;
         if (s_axi_araddr == DCC_OFF_PLL) begin
            rdata_next[0] = cfg_reg.crystal_16m_select;
         end else if (s_axi_araddr == DCC_OFF_SYS) begin
            rdata_next[7:0] = cfg_reg.sys;
         end else if (s_axi_araddr == DCC_OFF_BIT) begin
            rdata_next[7:0] = cfg_reg.bitdiv;
         end else if (s_axi_araddr == DCC_OFF_BITEN) begin
            rdata_next[0] = cfg_reg.biten;
         end else if (s_axi_araddr == DCC_OFF_SPDIF) begin
            rdata_next[7:0] = cfg_reg.spdif;
         end else if (s_axi_araddr == DCC_OFF_AUDIO) begin
            rdata_next[1:0] = cfg_reg.audio;
         end else if (s_axi_araddr == DCC_OFF_DBG) begin
            rdata_next[7:0] = cfg_reg.dbg;
         end else if (s_axi_araddr == DCC_OFF_STAT) begin
            rdata_next[7:0] = status;
         end else begin
            rresp_next = DCC_RESP_SLVERR;
         end
      end
   end

   // register the bus state
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_reg    <= '{crystal_16m_select: 1'b0, sys: DCC_RST_SYS, bitdiv: DCC_RST_BIT, biten: 1'b1,
                         spdif: DCC_RST_SPDIF, audio: 2'h0, dbg: DCC_RST_DBG};
         bvalid_reg <= 1'b0;
         bresp_reg  <= DCC_RESP_OKAY;
         rvalid_reg <= 1'b0;
         rresp_reg  <= DCC_RESP_OKAY;
         rdata_reg  <= 32'h0000_0000;
      end else begin
         cfg_reg    <= cfg_next;
         bvalid_reg <= bvalid_next;
         bresp_reg  <= bresp_next;
         rvalid_reg <= rvalid_next;
         rresp_reg  <= rresp_next;
         rdata_reg  <= rdata_next;
      end
   end

   // ===================== analog multiplier controls
   // multiply by eight
   assign pll_multiplier = DCC_PLL_MULT;
   assign crystal_halve  = cfg_reg.crystal_16m_select;

   // ===================== system clock divider
   // divider keeps pll tracking range
   logic [4:0] sys_cnt_reg, sys_cnt_next;   // free running xclk counter
   logic [2:0] sys_sel_reg, sys_sel_next;   // applied divider code
   logic       sleep_reg, sleep_next;       // applied sleep gate
   logic       sclk_reg, sclk_next;         // system clock level
   logic [10:0] acc_reg, acc_next;          // rf window sum
   dcc_rf_t    rf_reg, rf_next;             // averaged sample
   logic       win_end;                     // last xclk of system period
   logic [2:0] req_sel;                     // clipped requested code

   function automatic logic ones_below(input logic [4:0] c, input logic [2:0] s);
      logic r;
      r = 1'b1;
      for (int k = 0; k < 5; k++) begin
         if (k <= int'(s) && !c[k]) begin
            r = 1'b0;
         end
      end
      return r;
   endfunction

   assign req_sel = (cfg_reg.sys[2:0] > DCC_SYSTEM_DIVIDER_FIELD_MAX) ? DCC_SYSTEM_DIVIDER_FIELD_MAX : cfg_reg.sys[2:0];
   assign win_end = ones_below(sys_cnt_reg, sys_sel_reg);

   // system clock, sleep gate and rf averaging
   always_comb begin
      sys_cnt_next = sys_cnt_reg + 5'h01;
      sys_sel_next = sys_sel_reg;
      sleep_next   = sleep_reg;
      if (sys_cnt_reg == 5'h1F) begin
         sys_sel_next = req_sel;
         sleep_next   = cfg_reg.sys[DCC_SYS_SLEEP_BIT];
      end
      // counter bit gives /2 to /32
      sclk_next = sys_cnt_next[sys_sel_next] & ~sleep_next;
      rf_next.valid = win_end;
      rf_next.data  = rf_reg.data;
      if (win_end) begin
         acc_next     = 11'h000;
         rf_next.data = 6'((acc_reg + 11'(rf_sample_in)) >> (sys_sel_reg + 3'h1));
      end else begin
         acc_next = acc_reg + 11'(rf_sample_in);
      end
   end

   // register system clock state
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sys_cnt_reg <= 5'h00;
         sys_sel_reg <= 3'h0;
         sleep_reg   <= 1'b0;
         sclk_reg    <= 1'b0;
         acc_reg     <= 11'h000;
         rf_reg      <= '{valid: 1'b0, data: 6'h00};
      end else begin
         sys_cnt_reg <= sys_cnt_next;
         sys_sel_reg <= sys_sel_next;
         sleep_reg   <= sleep_next;
         sclk_reg    <= sclk_next;
         acc_reg     <= acc_next;
         rf_reg      <= rf_next;
      end
   end

   assign system_clock = sclk_reg;
   assign rf_average   = rf_reg;
   assign rf_sample_clock = reset_n;

   // ===================== programmable dividers
   // channel 0 bit, 1 spdif, 2 debug, 3 dac
   logic [7:0] ch_half [DCC_NCH];   // requested half period - 1
   logic       ch_en   [DCC_NCH];   // requested enable
   logic       ch_out  [DCC_NCH];   // divided clock levels
   logic       ch_app  [DCC_NCH];   // applied enable, for status

   assign ch_half[0] = cfg_reg.bitdiv;
   assign ch_en[0]   = cfg_reg.biten & ~cfg_reg.sys[DCC_SYS_SLEEP_BIT];
   assign ch_half[1] = cfg_reg.spdif;
   assign ch_en[1]   = cfg_reg.audio[DCC_AUD_SLAVE_BIT] & ~cfg_reg.sys[DCC_SYS_SLEEP_BIT];
   assign ch_half[2] = {4'h0, cfg_reg.dbg[3:0]};
   assign ch_en[2]   = ~cfg_reg.sys[DCC_SYS_SLEEP_BIT];
   assign ch_half[3] = {4'h0, cfg_reg.dbg[7:4]};
   assign ch_en[3]   = ~cfg_reg.sys[DCC_SYS_SLEEP_BIT];

   genvar gi;
   generate
      for (gi = 0; gi < DCC_NCH; gi++) begin : g_div
         logic [7:0] cnt_reg, cnt_next;     // half period countdown
         logic [7:0] half_reg, half_next;   // applied half period
         logic       en_reg, en_next;       // applied enable
         logic       out_reg, out_next;     // clock level

         // count halves, reload settings after a high half or while disabled
         always_comb begin
            cnt_next  = cnt_reg - 8'h01;
            half_next = half_reg;
            en_next   = en_reg;
            out_next  = out_reg;
            if (cnt_reg == 8'h00) begin
               if (out_reg || !en_reg) begin
                  // gate and divider change at period end
                  out_next  = 1'b0;
                  half_next = ch_half[gi];
                  en_next   = ch_en[gi];
                  cnt_next  = ch_half[gi];
               end else begin
                  out_next = 1'b1;
                  cnt_next = half_reg;
               end
            end
         end

         // register divider state
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               cnt_reg  <= 8'h00;
               half_reg <= 8'h00;
               en_reg   <= 1'b0;
               out_reg  <= 1'b0;
            end else begin
               cnt_reg  <= cnt_next;
               half_reg <= half_next;
               en_reg   <= en_next;
               out_reg  <= out_next;
            end
         end

         assign ch_out[gi] = out_reg;
         assign ch_app[gi] = en_reg;
      end
   endgenerate

   assign spdif_clock        = ch_out[1];
   assign debug_line_clock   = ch_out[2];
   assign external_dac_clock = ch_out[3];

   // ===================== serial bit clock source
   logic [1:0] bin_sync_reg, bin_sync_next;  // incoming bit clock synchroniser
   logic       bclk_reg, bclk_next;          // chosen backend clock
   logic       rx_mode;                      // receive incoming bit clock

   assign rx_mode = cfg_reg.audio[DCC_AUD_RX_BIT];

   // select internal divider or synchronised pin
   always_comb begin
      bin_sync_next = {bin_sync_reg[0], bit_clock_in};
      bclk_next = rx_mode ? bin_sync_reg[1] : ch_out[0];
   end

   // register bit clock source
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bin_sync_reg <= 2'h0;
         bclk_reg     <= 1'b0;
      end else begin
         bin_sync_reg <= bin_sync_next;
         bclk_reg     <= bclk_next;
      end
   end

   // backend and pin share bit clock
   assign backend_bit_clock = bclk_reg;
   assign bit_clock_out     = bclk_reg;
   assign bit_clock_oe      = ~rx_mode;

   // applied state view: sleep, divider code, applied enables
   assign status = {sleep_reg, sys_sel_reg, ch_app[3], ch_app[2], ch_app[1], ch_app[0]};

endmodule // dcc_clock_control

// ### test/dcc_props.sv
// checker of bus answers and clock outputs of the decoder clock control
`timescale 1ns/1ps
module dcc_props (
   input wire logic        clk,               // master clock
   input wire logic        reset_n,           // reset, active low
   input wire logic [7:0]  s_axi_awaddr,      // write address
   input wire logic        s_axi_awvalid,     // write address valid
   input wire logic        s_axi_awready,     // write address ready
   input wire logic [31:0] s_axi_wdata,       // write data
   input wire logic [3:0]  s_axi_wstrb,       // write strobes
   input wire logic        s_axi_wvalid,      // write data valid
   input wire logic [1:0]  s_axi_bresp,       // write response
   input wire logic        s_axi_bvalid,      // write response valid
   input wire logic        s_axi_bready,      // write response ready
   input wire logic [7:0]  s_axi_araddr,      // read address
   input wire logic        s_axi_arvalid,     // read address valid
   input wire logic        s_axi_arready,     // read address ready
   input wire logic [31:0] s_axi_rdata,       // read data
   input wire logic [1:0]  s_axi_rresp,       // read response
   input wire logic        s_axi_rvalid,      // read data valid
   input wire logic        s_axi_rready,      // read data ready
   input wire logic        bit_clock_in,      // incoming bit clock
   input wire logic        crystal_halve,     // pre-divide control
   input wire logic [3:0]  pll_multiplier,    // multiply control
   input wire logic        rf_sample_clock,   // capture enable
   input wire logic        backend_bit_clock, // backend clock
   input wire logic        bit_clock_oe       // bit clock pin enable
);
   import dcc_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ===================== clock controls
   // fixed multiplier
   a_mult_fixed: assert property (pll_multiplier == DCC_PLL_MULT)
      else $error("multiplier is not eight");
   a_halve_follow: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready
      && s_axi_wstrb[0] && s_axi_awaddr == DCC_OFF_PLL
      |-> ##2 crystal_halve == $past(s_axi_wdata[0], 2))
      else $error("crystal halve does not follow write");
   a_rf_running: assert property (rf_sample_clock)
      else $error("rf sample clock stopped");
   a_rx_follow: assert property (!bit_clock_oe && $rose(bit_clock_in)
      |-> ##[1:5] $rose(backend_bit_clock))
      else $error("backend does not follow pin clock");
   // ===================== register bus
   a_wr_okay: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready
      && s_axi_awaddr[1:0] == 2'h0 && s_axi_awaddr <= DCC_OFF_BITEN
      |=> s_axi_bvalid && s_axi_bresp == DCC_RESP_OKAY)
      else $error("mapped write not answered okay");
   a_rd_slverr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > DCC_OFF_BITEN
      |=> s_axi_rvalid && s_axi_rresp == DCC_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
endmodule // dcc_props

// ### test/dcc_far_model.sv
// far side model: incoming serial bit clock and rf converter samples
`timescale 1ns/1ps
module dcc_far_model (
   input  wire logic       clk,     // master clock
   input  wire logic       run,     // bit clock frame active
   output logic            bit_clk, // incoming bit clock
   output logic [5:0]      sample   // rf converter sample
);
   logic ph  = 1'b0; // free phase, unrelated to clk
   logic alt = 1'b0; // sample selector
   // external bit clock, held low outside frames
   always #34 ph = ~ph;
   assign bit_clk = run & ph;
   // one sample per master clock, two levels
   always_ff @(posedge clk) begin
      alt <= ~alt;
   end
   assign sample = alt ? 6'h30 : 6'h10;
endmodule // dcc_far_model

// ### test/tb_top.sv
// top testbench for the decoder clock control
`timescale 1ns/1ps
module tb_top;
   import dcc_pkg::*;
   // ===================== signals
   logic             clk = 1'b0, reset_n = 1'b0, run = 1'b0; // clock, reset, frame
   logic [7:0]       awaddr = 8'h00, araddr = 8'h00;         // addresses
   logic [31:0]      wdata = 32'h0;                          // write data
   logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire logic        awready, wready, bvalid, arready, rvalid, bclk, halve, rfclk;
   wire logic        sysclk, bitclk, bitout, oe, spclk, dbgclk, dacclk; // clock outputs
   wire logic [1:0]  bresp, rresp;                           // responses
   wire logic [31:0] rdata;                                  // read data
   wire logic [3:0]  mult;                                   // multiplier
   wire logic [5:0]  rfin;                                   // rf sample
   dcc_rf_t          rfavg;                                  // averaged sample
   wire logic [4:0]  clks = {dacclk, dbgclk, spclk, bitclk, sysclk}; // by index
   int               err_total = 0, checked = 0, cyc = 0;    // tallies
   always #4 clk = ~clk;
   dcc_clock_control uut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .bit_clock_in(bclk), .rf_sample_in(rfin), .crystal_halve(halve), .pll_multiplier(mult),
      .rf_sample_clock(rfclk), .system_clock(sysclk), .backend_bit_clock(bitclk),
      .bit_clock_out(bitout), .bit_clock_oe(oe), .spdif_clock(spclk),
      .debug_line_clock(dbgclk), .external_dac_clock(dacclk), .rf_average(rfavg));
   dcc_far_model far (.clk(clk), .run(run), .bit_clk(bclk), .sample(rfin));
   // ===================== shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // write: hold address and data until the response shows
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clk);
         #1;
      end while (bvalid !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      @(posedge clk);
      bready <= 1'b1;
      @(posedge clk);
      bready <= 1'b0;
   endtask
   // read: the answer stands until accepted
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clk);
         #1;
      end while (rvalid !== 1'b1);
      arvalid <= 1'b0;
      @(posedge clk);
      rready <= 1'b1;
      d = rdata;
      r = rresp;
      @(posedge clk);
      rready <= 1'b0;
   endtask
   // period and high time of one clock output, from a fresh rise
   task automatic per(input int i, output int p, output int h);
      for (h = 0; h < 300 && clks[i] !== 1'b0; h++) @(negedge clk);
      for (h = 0; h < 300 && clks[i] !== 1'b1; h++) @(negedge clk);
      for (h = 0; h < 300 && clks[i] === 1'b1; h++) @(negedge clk);
      for (p = h; p < 600 && clks[i] !== 1'b1; p++) @(negedge clk);
   endtask
   // high cycles of one clock output over 64 cycles
   task automatic quiet(input int i, output int hi);
      hi = 0;
      repeat (64) begin
         @(negedge clk);
         if (clks[i] !== 1'b0) hi++;
      end
   endtask
   // ===================== scenarios
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0]  r;
      logic [7:0]  a [7] = '{DCC_OFF_PLL, DCC_OFF_SYS, DCC_OFF_BIT, DCC_OFF_SPDIF,
                             DCC_OFF_AUDIO, DCC_OFF_DBG, DCC_OFF_BITEN};
      logic [7:0]  e [7] = '{8'h00, DCC_RST_SYS, DCC_RST_BIT, DCC_RST_SPDIF,
                             8'h00, DCC_RST_DBG, 8'h01};
      for (int k = 0; k < 7; k++) begin
         rd(a[k], d, r);
         check(d, {24'h0, e[k]});
         check(r, DCC_RESP_OKAY);
      end
      rd(8'h20, d, r);
      check(r, DCC_RESP_SLVERR);
      check(mult, DCC_PLL_MULT);
   endtask
   task automatic t_pll;
      wr(DCC_OFF_PLL, 32'h1);
      @(negedge clk);
      check(halve, 1'b1);
      wr(DCC_OFF_PLL, 32'h0);
      @(negedge clk);
      check(halve, 1'b0);
   endtask
   // every divider code, the last one out of range
   task automatic t_sys;
      int p, h, n;
      for (int c = 0; c < 6; c++) begin
         wr(DCC_OFF_SYS, (c == 5) ? 32'h7 : 32'(c));
         repeat (40) @(posedge clk);
         per(0, p, h);
         n = 2 << ((c > 4) ? 4 : c);
         check(p, n);
         check(h, n / 2);
         for (n = 0; n < 64 && rfavg.valid !== 1'b1; n++) @(negedge clk);
         check(rfavg.data, 6'h20);
      end
      wr(DCC_OFF_SYS, 32'h0);
   endtask
   task automatic t_dbg;
      int p, h;
      wr(DCC_OFF_DBG, 32'h21);
      repeat (40) @(posedge clk);
      per(3, p, h);
      check(p, 4);
      per(4, p, h);
      check(p, 6);
   endtask
   task automatic t_bit;
      int p, h;
      wr(DCC_OFF_BIT, 32'h2);
      repeat (40) @(posedge clk);
      per(1, p, h);
      check(p, 6);
      check(oe, 1'b1);
      check(bitout, bitclk);
      wr(DCC_OFF_BITEN, 32'h0);
      repeat (40) @(posedge clk);
      quiet(1, h);
      check(h, 0);
      wr(DCC_OFF_BITEN, 32'h1);
      wr(DCC_OFF_AUDIO, 32'h2);
      @(posedge clk);
      run <= 1'b1;
      repeat (20) @(posedge clk);
      per(1, p, h);
      check(oe, 1'b0);
      check(p >= 7 && p <= 10, 1'b1);
      @(posedge clk);
      run <= 1'b0;
      repeat (10) @(posedge clk);
      wr(DCC_OFF_AUDIO, 32'h0);
   endtask
   task automatic t_spdif;
      int p, h;
      quiet(2, h);
      check(h, 0);
      // software sets 64 times the sample rate
      wr(DCC_OFF_SPDIF, 32'hB);
      wr(DCC_OFF_AUDIO, 32'h1);
      repeat (40) @(posedge clk);
      per(2, p, h);
      check(p, 24);
   endtask
   task automatic t_sleep;
      int hi;
      logic [31:0] d;
      logic [1:0]  r;
      wr(DCC_OFF_SYS, 32'h8);
      repeat (40) @(posedge clk);
      for (int i = 0; i < 5; i++) begin
         quiet(i, hi);
         check(hi, 0);
      end
      check(rfclk, 1'b1);
      // applied view: asleep, code 0, every divider gated
      rd(DCC_OFF_STAT, d, r);
      check(d, 32'h0000_0080);
      check(r, DCC_RESP_OKAY);
      wr(DCC_OFF_SYS, 32'h0);
   endtask
   // ===================== run control
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         end_of_test;
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      t_reset;
      t_pll;
      t_sys;
      t_dbg;
      t_bit;
      t_spdif;
      t_sleep;
      end_of_test;
   end
endmodule // tb_top
bind dcc_clock_control dcc_props u_props (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready, .bit_clock_in, .crystal_halve, .pll_multiplier,
   .rf_sample_clock, .backend_bit_clock, .bit_clock_oe);
